// File: hw/core_voltage_setpoint_supervisor.sv
/*
  Digital supervisor around a core buck regulator: set-point and slew
  register, mode selection, fault hysteresis, power-good and battery flag.
  Assumes comparator inputs are asynchronous levels; pins are synchronised.
*/
`timescale 1ns/1ps
module core_voltage_setpoint_supervisor #(
  parameter int OV_CYCLES = supervisor_pkg::OV_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [1:0]  voltage_code_pins,
  input  wire logic        code_pin_mode_select,
  input  wire logic        enable_in,
  input  wire logic        out_above_114,
  input  wire logic        out_above_106,
  input  wire logic        out_below_86,
  input  wire logic        out_below_94,
  input  wire logic        overcurrent_in,
  input  wire logic        linear_rails_ok,
  input  wire logic        batt_above_2v8,
  input  wire logic        batt_below_2v6,
  input  wire logic        main_batt_present,
  output logic [3:0]       dac_code,
  output logic [10:0]      setpoint_mv,
  output logic [1:0]       ramp_select,
  output logic [5:0]       ramp_current_ua,
  output logic [5:0]       ramp_rate_tenths,
  output logic             core_enable,
  output logic             linear_regs_enable,
  output logic             low_quiescent,
  output logic             phase_tristate,
  output logic             current_limit,
  output logic             ov_fault,
  output logic             uv_fault,
  output logic             power_ok_flag,
  output logic             power_ok_flag_oe_n,
  output logic             battery_fault_n,
  output logic             battery_fault_from_backup
);
  setpoint_if sp ();

  // Two-flop synchronisers; the first stage feeds only the second
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic [NSYNC-1:0] raw;
  assign raw = {scl_in, sda_in, voltage_code_pins, code_pin_mode_select, enable_in,
                out_above_114, out_above_106, out_below_86, out_below_94,
                overcurrent_in, linear_rails_ok, batt_above_2v8, batt_below_2v6,
                main_batt_present};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  logic       scl_s;
  logic       sda_s;
  logic [1:0] pins_hi_s;
  logic       pin_mode_s;
  logic       en_s;
  logic       a114_s;
  logic       a106_s;
  logic       b86_s;
  logic       b94_s;
  logic       oc_s;
  logic       lin_ok_s;
  logic       b28_s;
  logic       b26_s;
  logic       batt_s;
  assign {scl_s, sda_s, pins_hi_s, pin_mode_s, en_s, a114_s, a106_s, b86_s, b94_s,
          oc_s, lin_ok_s, b28_s, b26_s, batt_s} = sync_q;

  function automatic logic [10:0] code_to_mv(input logic [3:0] code);
    code_to_mv = supervisor_pkg::BASE_MV + 11'(code) * supervisor_pkg::STEP_MV;
  endfunction

  function automatic logic [5:0] slew_to_ua(input logic [1:0] sel);
    case (sel)
      2'h0:    slew_to_ua = supervisor_pkg::I_SLEW0_UA;
      2'h1:    slew_to_ua = supervisor_pkg::I_SLEW1_UA;
      2'h2:    slew_to_ua = supervisor_pkg::I_SLEW2_UA;
      default: slew_to_ua = supervisor_pkg::I_SLEW3_UA;
    endcase
  endfunction

  function automatic logic [5:0] slew_to_rate(input logic [1:0] sel);
    case (sel)
      2'h0:    slew_to_rate = supervisor_pkg::RATE0_TENTHS;
      2'h1:    slew_to_rate = supervisor_pkg::RATE1_TENTHS;
      2'h2:    slew_to_rate = supervisor_pkg::RATE2_TENTHS;
      default: slew_to_rate = supervisor_pkg::RATE3_TENTHS;
    endcase
  endfunction

  // Serial slave; in code-pin mode the shared pins are code bits
  logic serial_mode;
  assign serial_mode = ~pin_mode_s;
  assign sp.scl     = serial_mode ? scl_s : 1'b1;
  assign sp.sda     = serial_mode ? sda_s : 1'b1;
  assign sp.accept  = serial_mode;

  // Program register survives enable cycles; only reset restores it
  logic [7:0] prog_q;
  assign sp.rd_data = prog_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prog_q <= supervisor_pkg::PROG_RESET;
    end else if (clk_en && sp.wr_stb && serial_mode) begin
      prog_q <= sp.wr_data;
    end
  end

  serial_byte_slave u_slave (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .sp      (sp)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (clk_en) begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~(sp.sda_drive & serial_mode);
    end
  end

  // Start-up phase: enabled but rails not yet seen in regulation
  logic started_q;
  logic init_q;
  logic rails_ok;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      started_q <= 1'b0;
      init_q    <= 1'b0;
    end else if (clk_en) begin
      if (rails_ok) begin
        started_q <= 1'b1;
      end
      if (en_s) begin
        init_q <= 1'b1;
      end
    end
  end

  logic [3:0] code_sel;
  logic [1:0] slew_sel;
  always_comb begin
    code_sel = serial_mode ? prog_q[supervisor_pkg::CODE_LSB +: supervisor_pkg::CODE_W]
                           : {pins_hi_s, sda_s, scl_s};
    if (!serial_mode || !started_q) begin
      slew_sel = supervisor_pkg::SLEW_FIXED;
    end else begin
      slew_sel = prog_q[supervisor_pkg::SLEW_LSB +: supervisor_pkg::SLEW_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dac_code         <= supervisor_pkg::CODE_DEFAULT;
      setpoint_mv      <= code_to_mv(supervisor_pkg::CODE_DEFAULT);
      ramp_select      <= supervisor_pkg::SLEW_DEFAULT;
      ramp_current_ua  <= supervisor_pkg::I_SLEW1_UA;
      ramp_rate_tenths <= supervisor_pkg::RATE1_TENTHS;
    end else if (clk_en) begin
      dac_code         <= code_sel;
      setpoint_mv      <= code_to_mv(code_sel);
      ramp_select      <= slew_sel;
      ramp_current_ua  <= slew_to_ua(slew_sel);
      ramp_rate_tenths <= slew_to_rate(slew_sel);
    end
  end

  // Enable: both linear regulators ride on the same pin as the core
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_enable        <= 1'b0;
      linear_regs_enable <= 1'b0;
      low_quiescent      <= 1'b0;
    end else if (clk_en) begin
      core_enable        <= en_s;
      linear_regs_enable <= en_s;
      low_quiescent      <= init_q & ~en_s;
    end
  end

  // Overvoltage needs a persistence window so switching spikes do not trip it
  logic [supervisor_pkg::OV_CNT_W-1:0] ov_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ov_cnt_q <= '0;
    end else if (clk_en) begin
      if (!a114_s || !en_s) begin
        ov_cnt_q <= '0;
      end else if (ov_cnt_q != supervisor_pkg::OV_CNT_W'(OV_CYCLES)) begin
        ov_cnt_q <= ov_cnt_q + 1'b1;
      end
    end
  end

  logic ov_trip;
  assign ov_trip = a114_s && en_s && (ov_cnt_q == supervisor_pkg::OV_CNT_W'(OV_CYCLES));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ov_fault       <= 1'b0;
      phase_tristate <= 1'b0;
    end else if (clk_en) begin
      if (ov_trip) begin
        ov_fault       <= 1'b1;
        phase_tristate <= 1'b1;
      end else if (!a106_s) begin
        ov_fault       <= 1'b0;
        phase_tristate <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      uv_fault <= 1'b0;
    end else if (clk_en) begin
      if (b86_s && started_q) begin
        uv_fault <= 1'b1;
      end else if (!b94_s) begin
        uv_fault <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      current_limit <= 1'b0;
    end else if (clk_en) begin
      current_limit <= oc_s & en_s;
    end
  end

  // Power good is registered from live faults, not latched, so it can chatter on a soft short
  assign rails_ok = en_s && lin_ok_s && !b94_s && !a114_s && !ov_fault && !uv_fault;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_ok_flag      <= 1'b0;
      power_ok_flag_oe_n <= 1'b0;
    end else if (clk_en) begin
      power_ok_flag      <= 1'b0;
      power_ok_flag_oe_n <= rails_ok;
    end
  end

  logic batt_good_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      batt_good_q <= 1'b0;
    end else if (clk_en) begin
      if (!batt_s) begin
        batt_good_q <= 1'b0;
      end else if (b28_s) begin
        batt_good_q <= 1'b1;
      end else if (b26_s) begin
        batt_good_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      battery_fault_n           <= 1'b0;
      battery_fault_from_backup <= 1'b1;
    end else if (clk_en) begin
      battery_fault_n           <= batt_good_q & batt_s;
      battery_fault_from_backup <= ~batt_s;
    end
  end

  sequence s_ov_held;
    clk_en && ov_trip;
  endsequence
  property p_ov_trip;
    @(posedge ref_clk) disable iff (reset) s_ov_held |=> ov_fault && phase_tristate;
  endproperty
  a_ov_trip: assert property (p_ov_trip) else $error("overvoltage did not trip");

  property p_ov_count;
    @(posedge ref_clk) disable iff (reset)
      $rose(ov_fault) |-> $past(ov_cnt_q) == supervisor_pkg::OV_CNT_W'(OV_CYCLES);
  endproperty
  a_ov_count: assert property (p_ov_count) else $error("overvoltage tripped early");

  property p_ov_hold;
    @(posedge ref_clk) disable iff (reset) (ov_fault && a106_s && clk_en) |=> ov_fault;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overvoltage cleared above 106");

  property p_uv_hold;
    @(posedge ref_clk) disable iff (reset) (uv_fault && b94_s && clk_en) |=> uv_fault;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("undervoltage cleared below 94");

  property p_pg_follow;
    @(posedge ref_clk) disable iff (reset) clk_en |=> power_ok_flag_oe_n == $past(rails_ok);
  endproperty
  a_pg_follow: assert property (p_pg_follow) else $error("power good not live");

  property p_pg_uv;
    @(posedge ref_clk) disable iff (reset) (clk_en && uv_fault) |=> !power_ok_flag_oe_n;
  endproperty
  a_pg_uv: assert property (p_pg_uv) else $error("power good released in fault");

  property p_prog_keep;
    @(posedge ref_clk) disable iff (reset) !sp.wr_stb |=> $stable(prog_q);
  endproperty
  a_prog_keep: assert property (p_prog_keep) else $error("program lost without write");

  property p_pin_fixed;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && !serial_mode) |=> ramp_select == supervisor_pkg::SLEW_FIXED;
  endproperty
  a_pin_fixed: assert property (p_pin_fixed) else $error("slew not fixed in pin mode");

  property p_no_ack_pin;
    @(posedge ref_clk) disable iff (reset) (clk_en && !serial_mode) |=> sda_oe_n;
  endproperty
  a_no_ack_pin: assert property (p_no_ack_pin) else $error("acked in pin mode");

  property p_lin_en;
    @(posedge ref_clk) disable iff (reset) clk_en |=> linear_regs_enable == core_enable;
  endproperty
  a_lin_en: assert property (p_lin_en) else $error("rails enabled apart");
endmodule // core_voltage_setpoint_supervisor

// File: hw/supervisor_pkg.sv
/*
  Constants, field layout, reset values and timing counts for the core
  voltage set-point supervisor. Assumes one 200 MHz clock.
*/
// Overview of operation
// - Set-point code D3..D0 means 850 mV plus 50 mV per step.
// - Converter code comes from the serial register or the four code pins.
// - D5..D4 pick ramp rate 0.5, 1, 2.5 or 5 mV/us with 10 nF.
// - After reset the slew field holds 01, the 10 uA source.
// - Slew 00 gives 5 uA, 10 gives 24 uA, 11 gives 47 uA.
// - Enable low after start: low quiescent, settings kept, set-point restored.
// - Start-up ramps at the 1 mV/us rate.
// - Output above 114 percent over 1.5 us trips overvoltage, floats switch node.
// - Overvoltage clears itself only at 106 percent.
// - Undervoltage sets below 86 percent and clears at 94 percent.
// - Overcurrent limits current; persisting, undervoltage drops power good.
// - Both linear regulators follow the shared enable.
// - Battery good above 2.8 V, kept until below 2.6 V.
// - With no main battery the fault pin is driven low from backup.
// - Power good held low until all three rails are in tolerance.
// - Power good is not latched and follows the live faults.
// - Serial mode powers up at the 1.3 V set-point.
// - Code-pin mode ignores slew bits and uses the fixed ramp.
// - Data byte latched at the acknowledge clock rise and applied at once.
package supervisor_pkg;
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          OV_TIME_NS    = 1500;
  localparam int          OV_CYCLES     = (OV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          OV_CNT_W      = 9;
  localparam int          CODE_LSB      = 0;
  localparam int          CODE_W        = 4;
  localparam int          SLEW_LSB      = 4;
  localparam int          SLEW_W        = 2;
  localparam logic [3:0]  CODE_DEFAULT  = 4'h9;
  localparam logic [1:0]  SLEW_DEFAULT  = 2'h1;
  localparam logic [1:0]  SLEW_FIXED    = 2'h1;
  localparam logic [7:0]  PROG_RESET    = {2'h0, SLEW_DEFAULT, CODE_DEFAULT};
  localparam logic [10:0] BASE_MV       = 11'h352;
  localparam logic [10:0] STEP_MV       = 11'h032;
  localparam logic [5:0]  I_SLEW0_UA    = 6'h05;
  localparam logic [5:0]  I_SLEW1_UA    = 6'h0a;
  localparam logic [5:0]  I_SLEW2_UA    = 6'h18;
  localparam logic [5:0]  I_SLEW3_UA    = 6'h2f;
  localparam logic [5:0]  RATE0_TENTHS  = 6'h05;
  localparam logic [5:0]  RATE1_TENTHS  = 6'h0a;
  localparam logic [5:0]  RATE2_TENTHS  = 6'h19;
  localparam logic [5:0]  RATE3_TENTHS  = 6'h32;
  // Bus address value is arbitrary
  localparam logic [6:0]  DEV_ADDR      = 7'h2a;
endpackage

// File: hw/setpoint_if.sv
/*
  Carrier between the supervisor and its serial byte slave.
  Assumes scl and sda are already synchronised to ref_clk.
*/
`timescale 1ns/1ps
interface setpoint_if;
  logic       scl;
  logic       sda;
  logic       accept;
  logic [7:0] rd_data;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       sda_drive;
  modport slave (input scl, sda, accept, rd_data, output wr_stb, wr_data, sda_drive);
  modport host  (output scl, sda, accept, rd_data, input wr_stb, wr_data, sda_drive);
endinterface

// File: hw/serial_byte_slave.sv
/*
  Two-wire bus slave holding one program byte: address, write and read.
  Assumes synchronised, oversampled scl and sda from the host modport.
*/
`timescale 1ns/1ps
module serial_byte_slave (
  input wire logic   ref_clk,
  input wire logic   reset,
  input wire logic   clk_en,
  setpoint_if.slave  sp
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_WDAT, S_WACK, S_RDAT, S_RACK, S_SKIP} slave_state_e;
  slave_state_e state_q;
  logic         scl_q;
  logic         sda_q;
  logic [7:0]   sh_q;
  logic [3:0]   cnt_q;
  logic         rw_q;
  logic         nack_q;
  logic         rise;
  logic         fall;
  logic         start;
  logic         stop;
  assign rise  = sp.scl & ~scl_q;
  assign fall  = ~sp.scl & scl_q;
  assign start = sp.scl & scl_q & sda_q & ~sp.sda;
  assign stop  = sp.scl & scl_q & ~sda_q & sp.sda;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sp.sda_drive <= 1'b0;
      sp.wr_stb <= 1'b0;
      sp.wr_data <= 8'h00;
    end else if (clk_en) begin
      sp.wr_stb <= 1'b0;
      scl_q <= sp.scl;
      sda_q <= sp.sda;
      if (start) begin
        state_q <= S_ADDR;
        cnt_q <= 4'h0;
        sp.sda_drive <= 1'b0;
      end else if (stop) begin
        state_q <= S_IDLE;
        sp.sda_drive <= 1'b0;
      end else if (rise) begin
        case (state_q)
          S_ADDR, S_WDAT: begin
            sh_q <= {sh_q[6:0], sp.sda};
            cnt_q <= cnt_q + 4'h1;
          end
          S_WACK: begin
            sp.wr_stb <= 1'b1;
            sp.wr_data <= sh_q;
          end
          S_RDAT: cnt_q <= cnt_q + 4'h1;
          S_RACK: nack_q <= sp.sda;
          default: ;
        endcase
      end else if (fall) begin
        case (state_q)
          S_ADDR: if (cnt_q == 4'h8) begin
            // Address not acknowledged in code-pin mode
            if (sh_q[7:1] == supervisor_pkg::DEV_ADDR && sp.accept) begin
              sp.sda_drive <= 1'b1;
              rw_q <= sh_q[0];
              state_q <= S_AACK;
            end else state_q <= S_SKIP;
          end
          S_AACK: begin
            cnt_q <= 4'h0;
            sh_q <= sp.rd_data;
            sp.sda_drive <= rw_q & ~sp.rd_data[7];
            state_q <= rw_q ? S_RDAT : S_WDAT;
          end
          S_WDAT: if (cnt_q == 4'h8) begin
            sp.sda_drive <= sp.accept;
            state_q <= sp.accept ? S_WACK : S_SKIP;
          end
          S_WACK: begin
            sp.sda_drive <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= S_WDAT;
          end
          S_RDAT: if (cnt_q == 4'h8) begin
            sp.sda_drive <= 1'b0;
            state_q <= S_RACK;
          end else begin
            sh_q <= {sh_q[6:0], 1'b0};
            sp.sda_drive <= ~sh_q[6];
          end
          S_RACK: begin
            cnt_q <= 4'h0;
            sh_q <= sp.rd_data;
            sp.sda_drive <= ~nack_q & ~sp.rd_data[7];
            state_q <= nack_q ? S_SKIP : S_RDAT;
          end
          default: ;
        endcase
      end
    end
  end

  property p_ack_latch;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && !start && !stop && rise && state_q == S_WACK) |=> sp.wr_stb;
  endproperty
  a_ack_latch: assert property (p_ack_latch) else $error("ack rise did not latch byte");
endmodule // serial_byte_slave

// File: tb/bus_host_model.sv
/*
  Host side of the two-wire bus: start, stop, byte writes and code pins.
  Assumes a pull-up on the data line and 9-clock bus phases.
*/
`timescale 1ns/1ps
module bus_host_model (
  input  wire logic ref_clk,
  input  wire logic dev_sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic host_low;
  // Pull-up wins only when both parties release the line
  assign sda = !(host_low || !dev_sda_oe_n);
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  task automatic drive(input logic c, input logic low);
    @(posedge ref_clk);
    scl <= c;
    host_low <= low;
    repeat (8) @(posedge ref_clk);
  endtask
  // Clock falls before data moves, so no false start or stop is seen
  task automatic bit_out(input logic b);
    drive(1'b0, host_low);
    drive(1'b0, !b);
    drive(1'b1, !b);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_out(1'b1);
    ack = !sda;
  endtask
  task automatic write(input logic [6:0] a, input logic [7:0] d, output logic [1:0] acks);
    drive(1'b1, 1'b1);
    send({a, 1'b0}, acks[1]);
    send(d, acks[0]);
    bit_out(1'b0);
    drive(1'b1, 1'b0);
  endtask
  // Master reads the program byte, then sends a not-acknowledge and a stop
  task automatic read(input logic [6:0] a, output logic [7:0] d, output logic ack);
    drive(1'b1, 1'b1);
    send({a, 1'b1}, ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(1'b1);
      d[i] = sda;
    end
    bit_out(1'b1);
    bit_out(1'b0);
    drive(1'b1, 1'b0);
  endtask
  task automatic pins(input logic [1:0] v);
    @(posedge ref_clk);
    scl <= v[0];
    host_low <= !v[1];
  endtask
endmodule // bus_host_model

// File: tb/tb_core_voltage_setpoint_supervisor.sv
/*
  Self-checking bench for the set-point supervisor with a bus host model.
  Assumes the design shortens the overvoltage count through OV_CYCLES.
*/
`timescale 1ns/1ps
module tb_core_voltage_setpoint_supervisor;
  localparam int OV_CYC = 4;
  logic ref_clk, reset, scl_in, sda_in, sda_oe_n, code_pin_mode_select, enable_in;
  logic out_above_114, out_above_106, out_below_86, out_below_94, overcurrent_in;
  logic linear_rails_ok, batt_above_2v8, batt_below_2v6, main_batt_present;
  logic core_enable, linear_regs_enable, low_quiescent, phase_tristate, current_limit;
  logic ov_fault, uv_fault, power_ok_flag_oe_n, battery_fault_n, battery_fault_from_backup;
  logic sda_out, power_ok_flag;
  logic [1:0]  voltage_code_pins, ramp_select, acks;
  logic [3:0]  dac_code;
  logic [7:0]  rd;
  logic [10:0] setpoint_mv;
  logic [5:0]  ramp_current_ua, ramp_rate_tenths;
  int          miscompares, check_count, cycles;
  logic [7:0]  bytes [4] = '{8'h00, 8'h1f, 8'h25, 8'h3a};
  int          cur [4] = '{5, 10, 24, 47};
  int          rate [4] = '{5, 10, 25, 50};

  core_voltage_setpoint_supervisor #(.OV_CYCLES(OV_CYC)) dut (
    .ref_clk, .reset, .clk_en(1'b1), .scl_in, .sda_in, .sda_out, .sda_oe_n,
    .voltage_code_pins, .code_pin_mode_select, .enable_in, .out_above_114, .out_above_106,
    .out_below_86, .out_below_94, .overcurrent_in, .linear_rails_ok, .batt_above_2v8,
    .batt_below_2v6, .main_batt_present, .dac_code, .setpoint_mv, .ramp_select,
    .ramp_current_ua, .ramp_rate_tenths, .core_enable, .linear_regs_enable, .low_quiescent,
    .phase_tristate, .current_limit, .ov_fault, .uv_fault, .power_ok_flag,
    .power_ok_flag_oe_n, .battery_fault_n, .battery_fault_from_backup);
  bus_host_model host (.ref_clk, .dev_sda_oe_n(sda_oe_n), .scl(scl_in), .sda(sda_in));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic test_reset();
    chk("code", 16'(4'h9), 16'(dac_code));
    chk("mv", 16'(1300), 16'(setpoint_mv));
    chk("slew", 16'(2'h1), 16'(ramp_select));
    chk("cur", 16'(10), 16'(ramp_current_ua));
    chk("rate", 16'(10), 16'(ramp_rate_tenths));
    chk("pg", 16'(1'b0), 16'(power_ok_flag_oe_n));
    chk("pgd", 16'(1'b0), 16'(power_ok_flag));
    chk("sdo", 16'(1'b0), 16'(sda_out));
    chk("bfn", 16'(1'b0), 16'(battery_fault_n));
    chk("bbk", 16'(1'b1), 16'(battery_fault_from_backup));
    $display("test reset done");
  endtask

  task automatic test_writes();
    @(posedge ref_clk) enable_in <= 1'b1;
    linear_rails_ok <= 1'b1;
    w(6);
    chk("core_en", 16'(1'b1), 16'(core_enable));
    chk("ldo_en", 16'(1'b1), 16'(linear_regs_enable));
    chk("pg", 16'(1'b1), 16'(power_ok_flag_oe_n));
    // Code steps include both ends of the range; every slew code once
    for (int i = 0; i < 4; i++) begin
      host.write(supervisor_pkg::DEV_ADDR, bytes[i], acks);
      w(1);
      chk("acks", 16'(2'b11), 16'(acks));
      chk("code", 16'(bytes[i][3:0]), 16'(dac_code));
      chk("mv", 16'(850 + 50 * bytes[i][3:0]), 16'(setpoint_mv));
      chk("slew", 16'(bytes[i][5:4]), 16'(ramp_select));
      chk("cur", 16'(cur[bytes[i][5:4]]), 16'(ramp_current_ua));
      chk("rate", 16'(rate[bytes[i][5:4]]), 16'(ramp_rate_tenths));
    end
    host.write(7'h15, 8'h01, acks);
    w(1);
    chk("acks", 16'(2'b00), 16'(acks));
    chk("code", 16'(4'ha), 16'(dac_code));
    // Read-back returns the last byte that was acknowledged
    host.read(supervisor_pkg::DEV_ADDR, rd, acks[1]);
    chk("rdack", 16'(1'b1), 16'(acks[1]));
    chk("rd", 16'(8'h3a), 16'(rd));
    $display("test writes done");
  endtask

  task automatic test_enable();
    @(posedge ref_clk) enable_in <= 1'b0;
    w(6);
    chk("lowq", 16'(1'b1), 16'(low_quiescent));
    chk("ldo_en", 16'(1'b0), 16'(linear_regs_enable));
    chk("pg", 16'(1'b0), 16'(power_ok_flag_oe_n));
    @(posedge ref_clk) enable_in <= 1'b1;
    w(6);
    chk("lowq", 16'(1'b0), 16'(low_quiescent));
    chk("code", 16'(4'ha), 16'(dac_code));
    chk("slew", 16'(2'h3), 16'(ramp_select));
    $display("test enable done");
  endtask

  task automatic test_faults();
    // Short excursion must not trip
    @(posedge ref_clk) out_above_114 <= 1'b1;
    w(2);
    out_above_114 <= 1'b0;
    w(8);
    chk("ov", 16'(1'b0), 16'(ov_fault));
    @(posedge ref_clk) out_above_114 <= 1'b1;
    out_above_106 <= 1'b1;
    w(OV_CYC + 8);
    chk("ov", 16'(1'b1), 16'(ov_fault));
    chk("tri", 16'(1'b1), 16'(phase_tristate));
    chk("pg", 16'(1'b0), 16'(power_ok_flag_oe_n));
    out_above_114 <= 1'b0;
    w(6);
    chk("ov", 16'(1'b1), 16'(ov_fault));
    out_above_106 <= 1'b0;
    w(6);
    chk("ov", 16'(1'b0), 16'(ov_fault));
    chk("pg", 16'(1'b1), 16'(power_ok_flag_oe_n));
    out_below_94 <= 1'b1;
    out_below_86 <= 1'b1;
    overcurrent_in <= 1'b1;
    w(6);
    chk("ilim", 16'(1'b1), 16'(current_limit));
    chk("uv", 16'(1'b1), 16'(uv_fault));
    chk("pg", 16'(1'b0), 16'(power_ok_flag_oe_n));
    out_below_86 <= 1'b0;
    overcurrent_in <= 1'b0;
    w(6);
    chk("uv", 16'(1'b1), 16'(uv_fault));
    out_below_94 <= 1'b0;
    w(6);
    chk("uv", 16'(1'b0), 16'(uv_fault));
    chk("pg", 16'(1'b1), 16'(power_ok_flag_oe_n));
    $display("test faults done");
  endtask

  task automatic test_battery();
    @(posedge ref_clk) main_batt_present <= 1'b1;
    batt_above_2v8 <= 1'b1;
    w(6);
    chk("bfn", 16'(1'b1), 16'(battery_fault_n));
    batt_above_2v8 <= 1'b0;
    w(6);
    chk("bfn", 16'(1'b1), 16'(battery_fault_n));
    batt_below_2v6 <= 1'b1;
    w(6);
    chk("bfn", 16'(1'b0), 16'(battery_fault_n));
    batt_below_2v6 <= 1'b0;
    batt_above_2v8 <= 1'b1;
    w(6);
    main_batt_present <= 1'b0;
    w(6);
    chk("bfn", 16'(1'b0), 16'(battery_fault_n));
    chk("bbk", 16'(1'b1), 16'(battery_fault_from_backup));
    $display("test battery done");
  endtask

  task automatic test_pins();
    @(posedge ref_clk) code_pin_mode_select <= 1'b1;
    voltage_code_pins <= 2'b11;
    host.pins(2'b10);
    w(6);
    chk("code", 16'(4'he), 16'(dac_code));
    chk("mv", 16'(1550), 16'(setpoint_mv));
    chk("slew", 16'(2'h1), 16'(ramp_select));
    host.write(supervisor_pkg::DEV_ADDR, 8'h00, acks);
    chk("acks", 16'(2'b00), 16'(acks));
    host.pins(2'b01);
    w(6);
    chk("code", 16'(4'hd), 16'(dac_code));
    @(posedge ref_clk) code_pin_mode_select <= 1'b0;
    host.pins(2'b11);
    w(6);
    chk("code", 16'(4'ha), 16'(dac_code));
    chk("slew", 16'(2'h3), 16'(ramp_select));
    $display("test pins done");
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    {reset, code_pin_mode_select, enable_in, voltage_code_pins} = 5'b10000;
    {out_above_114, out_above_106, out_below_86, out_below_94, overcurrent_in} = '0;
    {linear_rails_ok, batt_above_2v8, batt_below_2v6, main_batt_present} = '0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    w(4);
    test_reset();
    test_writes();
    test_enable();
    test_faults();
    test_battery();
    test_pins();
    report_and_stop();
  end
endmodule // tb_core_voltage_setpoint_supervisor
